// ===== core/qawdo_defines.svh
// Constants of the question-and-answer watchdog outcome block
`ifndef QAWDO_DEFINES_SVH
`define QAWDO_DEFINES_SVH
`define QAWDO_CNT_RELOAD   2'b11
`define QAWDO_CNT_LAST     2'b00
`define QAWDO_W1_NEEDED    3'h3
`define QAWDO_FLAG_WRONG   0
`define QAWDO_FLAG_EARLY   1
`define QAWDO_FLAG_ORDER   2
`define QAWDO_FLAG_TIMEOUT 3
`define QAWDO_NFLAGS       4
`define QAWDO_TALLY_MAX    3'h7
`define QAWDO_TALLY_MIN    3'h0
`define QAWDO_Q_W          4
`endif

// ===== core/qawdo_evt_if.sv
// Event carrier between the sequencer and the sticky status flags
`timescale 1ns/1ps
interface qawdo_evt_if;
    logic [3:0] set_flags;   // Flags raised this cycle
    logic [3:0] flags;       // Latched flags
    modport src (output set_flags, input flags);
    modport dst (input set_flags, output flags);
endinterface : qawdo_evt_if

// ===== core/qawdo_outcome.sv
// Outcome logic of the question-and-answer watchdog sequence
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "qawdo_defines.svh"
module qawdo_outcome #(
    parameter int TALLY_W = 3   // Width of the failure tally
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst,
    input  wire logic                  i_answer_wr,      // Answer byte written
    input  wire logic                  i_answer_ok,      // Byte matched reference
    input  wire logic                  i_win1_end,       // Window 1 expires pulse
    input  wire logic                  i_win2_end,       // Window 2 expires pulse
    input  wire logic                  i_rd,             // Register read strobe
    input  wire logic                  i_wr,             // Register write strobe
    input  wire logic [1:0]            i_addr,           // Register address
    input  wire logic [7:0]            i_wdata,          // Register write data
    output logic      [7:0]            o_rdata,          // Read data, cycle after
    output logic      [1:0]            o_answer_countdown,
    output logic      [`QAWDO_Q_W-1:0] o_question,
    output logic      [TALLY_W-1:0]    o_failure_tally,
    output logic                       o_bad_sequence_flag,
    output logic                       o_seq_start,      // New sequence pulse
    output logic                       o_irq
);
    import qawdo_pkg::*;

    // Register map
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_MASK   = 2'h1;
    localparam logic [1:0] ADDR_TALLY  = 2'h2;
    localparam logic [1:0] ADDR_QUEST  = 2'h3;

    // Whole state of the sequencer
    typedef struct packed {
        qawdo_win_t             win;     // Current window
        logic [1:0]             cnt;     // Answer countdown
        logic [2:0]             w1_cnt;  // Bytes taken in window 1
        logic                   wrong;   // A wrong byte seen
        logic                   early;   // All four in window 1
        logic                   order;   // Window 1 short
        logic                   bad;     // Bad-event flag
        logic [TALLY_W-1:0]     tally;   // Failure tally
        logic [`QAWDO_Q_W-1:0]  quest;   // Question counter
        logic [3:0]             mask;    // Interrupt mask
        logic [7:0]             rdata;   // Read data
        logic                   start;   // New sequence pulse
    } qawdo_st_t;

    qawdo_st_t   st, next_st;
    logic [3:0]  set_flags;
    logic [3:0]  clr_flags;
    qawdo_evt_if evt ();

    // Address match; used for the status and mask write decode
    function automatic logic hit(input logic [1:0] a, input logic [1:0] want);
        hit = (a == want);
    endfunction : hit

    qawdo_sticky u_sticky (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_clr  (clr_flags),
        .evt    (evt)
    );
    assign evt.set_flags = set_flags;
    // Write one to clear the status bits
    assign clr_flags = (i_wr && hit(i_addr, ADDR_STATUS)) ? i_wdata[3:0] : 4'h0;

    // Sequence outcome decision
    always_comb begin
        logic done;
        logic fail;
        logic last;
        done      = 1'b0;
        fail      = 1'b0;
        last      = 1'b0;
        next_st   = st;
        set_flags = 4'h0;
        next_st.start = 1'b0;
        // Answer byte arrives
        if (i_answer_wr) begin
            last = (st.cnt == `QAWDO_CNT_LAST);
            next_st.cnt = st.cnt - 2'h1;
            if (!i_answer_ok) begin
                next_st.wrong = 1'b1;
                next_st.bad   = 1'b1;
                set_flags[`QAWDO_FLAG_WRONG] = 1'b1;
            end
            if (st.win == QAWDO_WIN1) begin
                next_st.w1_cnt = st.w1_cnt + 3'h1;
                if (last) begin
                    // Four bytes inside window 1
                    next_st.early = 1'b1;
                    next_st.bad   = 1'b1;
                    set_flags[`QAWDO_FLAG_EARLY] = 1'b1;
                end
            end
            // Fourth byte in window 2 closes the sequence at once, no timeout
            if (last && st.win == QAWDO_WIN2) begin
                done = 1'b1;
            end
        end
        // Window 1 expiry
        if (i_win1_end && st.win == QAWDO_WIN1 && !done) begin
            next_st.win = QAWDO_WIN2;
            if (next_st.w1_cnt < `QAWDO_W1_NEEDED) begin
                next_st.order = 1'b1;
                next_st.bad   = 1'b1;
                set_flags[`QAWDO_FLAG_ORDER] = 1'b1;
            end
        end
        // Window 2 expiry with fewer than four bytes is a timeout
        if (i_win2_end && st.win == QAWDO_WIN2 && !done) begin
            done = 1'b1;
            set_flags[`QAWDO_FLAG_TIMEOUT] = 1'b1;
            fail = 1'b1;
        end
        if (done) begin
            fail = fail | next_st.wrong | next_st.early | next_st.order;
            // Tally moves once per sequence and saturates
            if (fail) begin
                if (st.tally != TALLY_W'(`QAWDO_TALLY_MAX))
                    next_st.tally = st.tally + TALLY_W'(1);
            end else begin
                if (st.tally != TALLY_W'(`QAWDO_TALLY_MIN))
                    next_st.tally = st.tally - TALLY_W'(1);
                next_st.quest = st.quest + `QAWDO_Q_W'(1);
            end
            // Failed sequence keeps the question: no increment above
            next_st.cnt    = `QAWDO_CNT_RELOAD;
            next_st.w1_cnt = 3'h0;
            next_st.win    = QAWDO_WIN1;
            next_st.wrong  = 1'b0;
            next_st.early  = 1'b0;
            next_st.order  = 1'b0;
            next_st.bad    = 1'b0;
            next_st.start  = 1'b1;
        end
        // Mask register write
        if (i_wr && hit(i_addr, ADDR_MASK)) begin
            next_st.mask = i_wdata[3:0];
        end
        // Read data valid the cycle after the strobe only
        next_st.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                ADDR_STATUS: next_st.rdata = {3'h0, st.bad, evt.flags};
                ADDR_MASK:   next_st.rdata = {4'h0, st.mask};
                ADDR_TALLY:  next_st.rdata = 8'(st.tally);
                ADDR_QUEST:  next_st.rdata = {2'h0, st.cnt, st.quest};
                default:     next_st.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st     <= '0;
            st.win <= QAWDO_WIN1;
            st.cnt <= `QAWDO_CNT_RELOAD;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata             = st.rdata;
    assign o_answer_countdown  = st.cnt;
    assign o_question          = st.quest;
    assign o_failure_tally     = st.tally;
    assign o_bad_sequence_flag = st.bad;
    assign o_seq_start         = st.start;
    assign o_irq               = |(evt.flags & st.mask);

    chk_reload_on_start: assert property (@(posedge i_mclk) disable iff (i_rst)
        st.start |-> st.cnt == `QAWDO_CNT_RELOAD && st.w1_cnt == 3'h0)
        else $error("countdown not reloaded at new sequence");
    chk_fourth_late_ends: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_answer_wr && st.cnt == `QAWDO_CNT_LAST && st.win == QAWDO_WIN2)
        |=> st.start && !evt.flags[`QAWDO_FLAG_TIMEOUT] || $past(evt.flags[`QAWDO_FLAG_TIMEOUT]))
        else $error("late fourth byte did not end sequence");
    chk_fail_same_q: assert property (@(posedge i_mclk) disable iff (i_rst)
        (st.start && $past(st.wrong | st.early | st.order)) |-> $stable(st.quest))
        else $error("question advanced after flawed sequence");
    chk_good_new_q: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_answer_wr && i_answer_ok && st.cnt == `QAWDO_CNT_LAST && st.win == QAWDO_WIN2
         && !st.wrong && !st.early && !st.order && !i_win2_end)
        |=> st.quest == $past(st.quest) + `QAWDO_Q_W'(1))
        else $error("good sequence did not advance question");
    chk_fail_tally_up: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_win2_end && st.win == QAWDO_WIN2 && !i_answer_wr
         && st.tally != TALLY_W'(`QAWDO_TALLY_MAX))
        |=> st.tally == $past(st.tally) + TALLY_W'(1))
        else $error("timeout did not raise tally");
    chk_w1_short_order: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_win1_end && st.win == QAWDO_WIN1 && st.w1_cnt == 3'h0 && !i_answer_wr)
        |=> evt.flags[`QAWDO_FLAG_ORDER] && st.bad)
        else $error("short window 1 not flagged");
    chk_timeout_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_win2_end && st.win == QAWDO_WIN2 && !i_answer_wr)
        |=> evt.flags[`QAWDO_FLAG_TIMEOUT] ##0 st.start)
        else $error("window 2 expiry without timeout flag");
    chk_wrong_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_answer_wr && !i_answer_ok) |=> evt.flags[`QAWDO_FLAG_WRONG])
        else $error("wrong byte not flagged");
    chk_early_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_answer_wr && st.cnt == `QAWDO_CNT_LAST && st.win == QAWDO_WIN1)
        |=> evt.flags[`QAWDO_FLAG_EARLY])
        else $error("early answers not flagged");

    cov_timeout: cover property (@(posedge i_mclk) disable iff (i_rst)
        i_win2_end && st.win == QAWDO_WIN2);
    cov_good: cover property (@(posedge i_mclk) disable iff (i_rst)
        st.start && st.quest != $past(st.quest));
    cov_late_four: cover property (@(posedge i_mclk) disable iff (i_rst)
        i_answer_wr && st.cnt == `QAWDO_CNT_LAST && st.win == QAWDO_WIN2 && st.w1_cnt == 3'h0);
endmodule : qawdo_outcome

// ===== core/qawdo_pkg.sv
// Types of the question-and-answer watchdog outcome block
package qawdo_pkg;
    // Window in which the current sequence stands
    typedef enum logic [1:0] {
        QAWDO_WIN1,
        QAWDO_WIN2
    } qawdo_win_t;
endpackage : qawdo_pkg

// ===== core/qawdo_sticky.sv
// Sticky status flags, write one to clear, set wins over clear
`timescale 1ns/1ps
`include "qawdo_defines.svh"
module qawdo_sticky (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_clr,
    qawdo_evt_if.dst        evt
);
    import qawdo_pkg::*;
    typedef struct packed { logic [3:0] flags; } qawdo_stk_t;
    qawdo_stk_t st, next_st;

    // Set beats clear in the same cycle so no event is lost
    always_comb begin
        next_st.flags = (st.flags & ~i_clr) | evt.set_flags;
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign evt.flags = st.flags;

    chk_flag_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
        ($past(st.flags) & ~$past(i_clr)) == (($past(st.flags) & ~$past(i_clr)) & st.flags))
        else $error("latched flag dropped without a clear");
endmodule : qawdo_sticky

// ===== sim/qawdo_host.sv
// Host-side model that writes watchdog answer bytes
`timescale 1ns/1ps
module qawdo_host (
    input  wire logic i_mclk,
    output logic      o_answer_wr,
    output logic      o_answer_ok
);
    // Idle at start, no byte pending
    initial begin
        o_answer_wr = 1'b0;
        o_answer_ok = 1'b0;
    end
    // One byte a cycle wide, then a rest cycle
    task automatic send(input logic ok);
        @(posedge i_mclk);
        o_answer_wr <= 1'b1;
        o_answer_ok <= ok;
        @(posedge i_mclk);
        o_answer_wr <= 1'b0;
        // Quality line inverted so a stale level is never trusted
        o_answer_ok <= ~ok;
    endtask : send
endmodule : qawdo_host

// ===== sim/tb_top.sv
// Self-checking bench for the watchdog sequence outcome block
`timescale 1ns/1ps
module tb_top;
    logic       i_mclk  = 1'b0;  // 200 MHz clock
    logic       i_rst   = 1'b1;  // Async reset
    logic       w1_end  = 1'b0;  // Window 1 expiry pulse
    logic       w2_end  = 1'b0;  // Window 2 expiry pulse
    logic       i_rd    = 1'b0;
    logic       i_wr    = 1'b0;
    logic [1:0] i_addr  = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] rdata;           // Read data from the block
    logic [7:0] rd;              // Captured read value
    logic [1:0] cnt;
    logic [3:0] q;
    logic [3:0] q0;              // Question before the sequence
    logic [2:0] tally;
    logic       bad, start, irq, wr, ans_ok, ok, flawed;
    int         errors   = 0;
    int         n_checks = 0;
    int         seed     = 64363;
    int         tmdl     = 0;    // Modelled failure tally
    int         qmdl     = 0;    // Modelled question counter
    int         n_starts = 0;    // New-sequence pulses seen
    int         n1, n2, r, wrong;

    // Free-running clock
    always #2.5 i_mclk = ~i_mclk;

    // Count sequence start pulses, one per ended sequence
    always @(posedge i_mclk) begin
        if (start === 1'b1) n_starts <= n_starts + 1;
    end

    qawdo_host i_host (.i_mclk(i_mclk), .o_answer_wr(wr), .o_answer_ok(ans_ok));

    qawdo_outcome i_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_answer_wr(wr), .i_answer_ok(ans_ok),
        .i_win1_end(w1_end), .i_win2_end(w2_end), .i_rd(i_rd), .i_wr(i_wr),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(rdata), .o_answer_countdown(cnt),
        .o_question(q), .o_failure_tally(tally), .o_bad_sequence_flag(bad),
        .o_seq_start(start), .o_irq(irq));

    // One compare for every result kind
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Verdict and end of run
    task automatic summarize;
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Window expiry pulse, one cycle
    task automatic pulse(input bit two);
        @(posedge i_mclk);
        if (two) w2_end <= 1'b1;
        else w1_end <= 1'b1;
        @(posedge i_mclk);
        w1_end <= 1'b0;
        w2_end <= 1'b0;
    endtask : pulse

    // Register write, one strobe cycle
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr_reg

    // Register read, data taken in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rd = rdata;
    endtask : rd_reg

    // Hang guard, far beyond the expected run length
    initial begin
        #200000;
        errors++;
        summarize();
    end

    // Main sequence: random answer counts per window, every fifth run good
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1 chk("countdown", 8'h03, {6'h0, cnt});
        wr_reg(2'h1, 8'h0f);
        for (int i = 0; i < 40; i++) begin
            r  = $unsigned($random(seed)) % 3;
            n1 = (i % 5 == 0) ? 3 : (i == 1) ? 0 : $unsigned($random(seed)) % 4;
            n2 = (i % 5 == 0) ? 1 : (i == 1 || r == 0) ? 0 : (r == 1) ? 1 : 4 - n1;
            q0 = q;
            wrong = 0;
            repeat (n1) begin
                ok = (i % 5 == 0) || ($random(seed) % 4 != 0);
                wrong |= !ok;
                i_host.send(ok);
            end
            pulse(1'b0);
            if (n1 < 3) #1 chk("bad flag", 8'h01, {7'h0, bad});
            repeat (n2) begin
                ok = (i % 5 == 0) || ($random(seed) % 4 != 0);
                wrong |= !ok;
                i_host.send(ok);
            end
            // Short of four bytes the cycle only ends at window 2 expiry
            if (n1 + n2 < 4) pulse(1'b1);
            #1;
            flawed = (wrong != 0) || n1 < 3 || n1 + n2 < 4;
            tmdl = flawed ? (tmdl < 7 ? tmdl + 1 : 7) : (tmdl > 0 ? tmdl - 1 : 0);
            chk("tally", 8'(tmdl), {5'h0, tally});
            chk("question kept", {7'h0, flawed}, {7'h0, q === q0});
            chk("countdown", 8'h03, {6'h0, cnt});
            if (!flawed) qmdl = (qmdl + 1) % 16;
            chk("question", 8'(qmdl), {4'h0, q});
            chk("bad cleared", 8'h00, {7'h0, bad});
            rd_reg(2'h3);
            chk("quest reg", {2'h0, 2'b11, 4'(qmdl)}, rd);
            rd_reg(2'h0);
            chk("starts", 8'(i + 1), 8'(n_starts));
            chk("status", {4'h0, n1 + n2 < 4, n1 < 3, 1'b0, wrong != 0}, rd);
            chk("irq", {7'h0, flawed}, {7'h0, irq});
            if (i == 3) begin
                wr_reg(2'h1, 8'h00);
                #1 chk("irq masked", 8'h00, {7'h0, irq});
                wr_reg(2'h2, 8'h55);
                rd_reg(2'h2);
                chk("tally ro", 8'(tmdl), rd);
                wr_reg(2'h1, 8'h0f);
            end
            wr_reg(2'h0, 8'h0f);
            rd_reg(2'h0);
            chk("status cleared", 8'h00, rd);
        end
        summarize();
    end
endmodule : tb_top
